// ---- rtl/prs_sequencer.sv ----
// Operation
// R1 - Regulators enable whenever either power-on input is high.
// R2 - WLAN section held in reset while its power-on input is low.
// R3 - All regulators power down only when both power-on inputs are low.
// R4 - Buck, core linear and low-noise linear come up once either input rises.
// R5 - Core linear and low-noise linear follow sequencer resource needs.
// R6 - Radio core reset is active low and touches only the radio core.
// R7 - Host always drives the radio core reset to a defined level.
// R8 - Switcher hold request keeps the core buck on regardless of power-on inputs.
// R9 - Powered and held, a full-power request forces PWM; higher mode wins.
// R10 - Requests come from clock requests, minimum mask and request timers.
// R11 - Each resource is disabled, turning on, enabled or turning off.
// R12 - A starting transition loads the enable or disable delay.
// R13 - Counters decrement once per low-power tick, finishing the transition at zero.
// R14 - Zero delay transitions happen immediately without counting.
// R15 - Each tick computes the needed set then compares with status.
// R16 - Nonzero counters decrement; at zero pending clears and state inverts.
// R17 - Disable enabled resources no longer needed with no live dependents.
// R18 - Enable disabled needed resources whose dependencies are all enabled.
// R19 - Doze stops main clocks; only the low-power tick drives the sequencer.
// R20 - Power-down turns every regulator off; outside logic must re-enable. The core buck stays on while the switcher hold request is high.
// R21 - Low-power shutdown tristates outputs and disables most inputs.
// R22 - Power-on after shutdown behaves as a first power-up.
// R23 - Delays, dependency table and minimum mask are writable configuration.
//
// Top of the power resource sequencer.
// Assumes all inputs are synchronous to CLOCK and LPO_CLOCK_IN is a slow level.
`timescale 1ns/1ps
`include "prs_regs.svh"
module prs_sequencer
    import prs_pkg::*;
#(
    parameter int                 NRES    = 8,
    parameter int                 DW      = 8,
    parameter int                 NCLK    = 4,
    parameter logic [4*8-1:0]     CLK_MAP = 32'h0f_0f_0b_08
) (
    input  wire logic             CLOCK,
    input  wire logic             RST,
    input  wire logic             WLAN_POWER_ON_INPUT,
    input  wire logic             RADIO_POWER_ON_INPUT,
    input  wire logic             RADIO_CORE_RESET_N,
    input  wire logic             SWITCHER_HOLD_REQUEST,
    input  wire logic             BUCK_FULL_POWER_REQUEST,
    input  wire logic             BUCK_PWM_INTERNAL_REQ,
    input  wire logic             LPO_CLOCK_IN,
    input  wire logic [NCLK-1:0]  CORE_CLOCK_REQ,
    input  wire logic [NRES-1:0]  TIMER_REQ,
    input  wire logic             CFG_WE,
    input  wire logic [1:0]       CFG_SEL,
    input  wire logic [$clog2(NRES)-1:0] CFG_IDX,
    input  wire logic [DW-1:0]    CFG_DATA,
    output logic                  REG_ENABLE,
    output logic                  BUCK_ENABLE,
    output logic                  BUCK_PWM_MODE,
    output logic                  CORE_LINEAR_ENABLE,
    output logic                  LOW_NOISE_ENABLE,
    output logic                  WLAN_SECTION_RESET,
    output logic                  RADIO_CORE_RESET,
    output logic                  MAIN_CLOCK_ENABLE,
    output logic                  DOZE_STATE,
    output logic                  IO_OUTPUT_ENABLE_N,
    output logic                  IO_INPUT_ENABLE,
    output logic [NRES-1:0]       RESOURCE_STATE_FLAG,
    output logic [NRES-1:0]       RESOURCE_PENDING_FLAG
);
    // Clock requests widened to resource masks by a fixed map
    function automatic logic [NRES-1:0] clk_map(input logic [NCLK-1:0] req);
        logic [NRES-1:0] m;
        m = '0;
        for (int c = 0; c < NCLK; c++) begin
            if (req[c]) begin
                m = m | NRES'(CLK_MAP[c*8 +: 8]);
            end
        end
        return m;
    endfunction : clk_map

    // Requested set grown by the dependency table until closed
    function automatic logic [NRES-1:0] closure(input logic [NRES-1:0] req,
                                                 input logic [NRES-1:0] dep [NRES]);
        logic [NRES-1:0] n;
        n = req;
        for (int k = 0; k < NRES; k++) begin
            for (int i = 0; i < NRES; i++) begin
                if (n[i]) begin
                    n = n | dep[i];
                end
            end
        end
        return n;
    endfunction : closure

    prs_timer_if #(.NRES(NRES), .DW(DW)) tif ();

    prs_timer_bank #(.NRES(NRES), .DW(DW)) u_bank (
        .clk (CLOCK),
        .rst (RST),
        .tb  (tif)
    );

    logic            wl_q;
    logic            bt_q;
    logic            hold_q;
    logic            full_q;
    logic            pwm_int_q;
    logic            lpo_q;
    logic            lpo_qq;
    logic [NCLK-1:0] clkreq_q;
    logic [NRES-1:0] tmr_q;
    logic [DW-1:0]   on_dly_q  [NRES];
    logic [DW-1:0]   off_dly_q [NRES];
    logic [NRES-1:0] dep_q     [NRES];
    logic [NRES-1:0] min_q;

    // Pin capture; the radio core reset input is not captured and only feeds the radio core reset output
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            wl_q      <= 1'b0;
            bt_q      <= 1'b0;
            hold_q    <= 1'b0;
            full_q    <= 1'b0;
            pwm_int_q <= 1'b0;
            lpo_q     <= 1'b0;
            lpo_qq    <= 1'b0;
            clkreq_q  <= '0;
            tmr_q     <= '0;
        end else begin
            wl_q      <= WLAN_POWER_ON_INPUT;
            bt_q      <= RADIO_POWER_ON_INPUT;
            hold_q    <= SWITCHER_HOLD_REQUEST;
            full_q    <= BUCK_FULL_POWER_REQUEST;
            pwm_int_q <= BUCK_PWM_INTERNAL_REQ;
            lpo_q     <= LPO_CLOCK_IN;
            lpo_qq    <= lpo_q;
            clkreq_q  <= CORE_CLOCK_REQ;
            tmr_q     <= TIMER_REQ;
        end
    end

    // Power state decode
    logic any_on;
    logic power_down;
    logic tick;
    assign any_on     = wl_q | bt_q; // R1
    assign power_down = ~any_on; // R3 R20
    assign tick       = lpo_q & ~lpo_qq & any_on; // R13 R19

    // Configuration storage; lost in power-down so the next power-on is a fresh one
    always_ff @(posedge CLOCK) begin
        if (RST || power_down) begin
            on_dly_q  <= '{default: DW'(`PRS_DLY_RESET)}; // R22
            off_dly_q <= '{default: DW'(`PRS_DLY_RESET)};
            dep_q     <= '{default: NRES'(`PRS_DEP_RESET)};
            min_q     <= NRES'(`PRS_MIN_RESET);
        end else if (CFG_WE) begin
            unique case (CFG_SEL)
                `PRS_SEL_ON_DLY:  on_dly_q[CFG_IDX]  <= CFG_DATA; // R23
                `PRS_SEL_OFF_DLY: off_dly_q[CFG_IDX] <= CFG_DATA;
                `PRS_SEL_DEPS:    dep_q[CFG_IDX]     <= NRES'(CFG_DATA);
                `PRS_SEL_MIN:     min_q              <= NRES'(CFG_DATA);
            endcase
        end
    end

    // Request set, its closure, and the liveness of each resource
    logic [NRES-1:0] req_w;
    logic [NRES-1:0] need_w;
    logic [NRES-1:0] live_w;
    logic [NRES-1:0] enab_w;
    logic [NRES-1:0] dep_up_w;
    logic [NRES-1:0] deps_ok_w;
    logic [NRES-1:0] idle_w;
    assign req_w  = clk_map(clkreq_q) | min_q | tmr_q; // R10
    assign need_w = closure(req_w, dep_q); // R15
    assign live_w = tif.state | tif.pending;
    assign enab_w = tif.state & ~tif.pending;
    assign idle_w = ~tif.pending;

    // A resource is blocked from turning off while any dependent is live
    always_comb begin
        for (int j = 0; j < NRES; j++) begin
            dep_up_w[j]  = 1'b0;
            deps_ok_w[j] = ((dep_q[j] & ~enab_w) == '0);
            for (int i = 0; i < NRES; i++) begin
                if (live_w[i] && dep_q[i][j] && i != j) begin
                    dep_up_w[j] = 1'b1;
                end
            end
        end
    end

    // Starts are compared against status; the bank only acts on a tick or on the power-down clear
    assign tif.tick      = tick; // R15
    assign tif.clr       = power_down;
    assign tif.start_off = tif.state & idle_w & ~need_w & ~dep_up_w; // R17
    assign tif.start_on  = ~tif.state & idle_w & need_w & deps_ok_w; // R18
    assign tif.on_dly    = on_dly_q;
    assign tif.off_dly   = off_dly_q;

    // Output decode; higher-power buck mode wins a conflict by OR
    logic buck_w;
    logic pwm_w;
    logic core_linear_regulator_w;
    logic low_noise_linear_regulator_w;
    logic mclk_w;
    assign buck_w  = any_on | hold_q; // R4 R8
    assign pwm_w   = (any_on & hold_q & full_q) | (buck_w & pwm_int_q); // R9
    assign core_linear_regulator_w  = any_on & tif.state[`PRS_RES_CORE_LDO]; // R4 R5
    assign low_noise_linear_regulator_w = any_on & tif.state[`PRS_RES_LN_LDO]; // R4 R5
    assign mclk_w  = any_on & tif.state[`PRS_RES_MAIN_CLK]; // R19

    // All outputs registered; shutdown tristates pads and closes inputs
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            REG_ENABLE            <= 1'b0;
            BUCK_ENABLE           <= 1'b0;
            BUCK_PWM_MODE         <= 1'b0;
            CORE_LINEAR_ENABLE    <= 1'b0;
            LOW_NOISE_ENABLE      <= 1'b0;
            WLAN_SECTION_RESET    <= 1'b1;
            RADIO_CORE_RESET      <= 1'b1;
            MAIN_CLOCK_ENABLE     <= 1'b0;
            DOZE_STATE            <= 1'b0;
            IO_OUTPUT_ENABLE_N    <= 1'b1;
            IO_INPUT_ENABLE       <= 1'b0;
            RESOURCE_STATE_FLAG   <= '0;
            RESOURCE_PENDING_FLAG <= '0;
        end else begin
            REG_ENABLE            <= any_on; // R1 R3
            BUCK_ENABLE           <= buck_w; // R8
            BUCK_PWM_MODE         <= pwm_w; // R9
            CORE_LINEAR_ENABLE    <= core_linear_regulator_w; // R5
            LOW_NOISE_ENABLE      <= low_noise_linear_regulator_w; // R5
            WLAN_SECTION_RESET    <= ~wl_q; // R2
            RADIO_CORE_RESET      <= ~RADIO_CORE_RESET_N; // R6 R7
            MAIN_CLOCK_ENABLE     <= mclk_w; // R19
            DOZE_STATE            <= any_on & ~mclk_w; // R19
            IO_OUTPUT_ENABLE_N    <= power_down; // R21
            IO_INPUT_ENABLE       <= any_on; // R21
            RESOURCE_STATE_FLAG   <= tif.state;
            RESOURCE_PENDING_FLAG <= tif.pending;
        end
    end

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);

    reg_or_a: assert property (!$past(RST) && !$past(RST, 2) |->
        REG_ENABLE == ($past(WLAN_POWER_ON_INPUT, 2) || $past(RADIO_POWER_ON_INPUT, 2))) // R1
        else $error("regulator enable is not the OR of the power-on inputs");
    wlan_reset_a: assert property (!$past(RST) && !$past(RST, 2) |->
        WLAN_SECTION_RESET == !$past(WLAN_POWER_ON_INPUT, 2)) // R2
        else $error("WLAN section reset does not follow its power-on input");
    all_off_a: assert property (!REG_ENABLE |-> !CORE_LINEAR_ENABLE && !LOW_NOISE_ENABLE
        && !MAIN_CLOCK_ENABLE && BUCK_ENABLE == $past(hold_q)) // R3
        else $error("a regulator stayed on in power-down");
    buck_hold_a: assert property (hold_q |=> BUCK_ENABLE) // R8
        else $error("hold request did not keep the buck on");
    pwm_force_a: assert property (any_on && hold_q && full_q |=> BUCK_PWM_MODE && BUCK_ENABLE) // R9
        else $error("full-power request did not force PWM");
    radio_rst_a: assert property (!$past(RST) |-> RADIO_CORE_RESET == !$past(RADIO_CORE_RESET_N)) // R6
        else $error("radio core reset is not the inverse of its pin");
    start_off_a: assert property (!$past(RST) && !$past(power_down) |-> // R17
        ($past(enab_w) & ~enab_w & ($past(need_w) | $past(dep_up_w))) == '0)
        else $error("disable started for a needed resource");
    enable_dep_a: assert property (!$past(RST) |-> (live_w & ~$past(live_w) & ~$past(deps_ok_w)) == '0) // R18
        else $error("enable started before a dependency was enabled");
    io_shut_a: assert property (power_down |=> IO_OUTPUT_ENABLE_N && !IO_INPUT_ENABLE) // R21
        else $error("pads not released in shutdown");
    doze_clk_a: assert property (DOZE_STATE |-> !MAIN_CLOCK_ENABLE && REG_ENABLE) // R19
        else $error("main clock running in doze");
    cfg_lost_a: assert property (power_down |=> min_q == NRES'(`PRS_MIN_RESET)) // R22
        else $error("configuration kept through power-down");
    flag_copy_a: assert property (!$past(RST) |-> RESOURCE_STATE_FLAG == $past(tif.state)) // R11
        else $error("state flags do not follow the sequencer");

    hold_only_c: cover property (power_down && hold_q ##1 BUCK_ENABLE && !REG_ENABLE);
    pwm_forced_c: cover property (BUCK_PWM_MODE && !pwm_int_q);
    doze_c: cover property (MAIN_CLOCK_ENABLE ##[1:1000] DOZE_STATE);
    dep_chain_c: cover property (tick && (tif.state & idle_w & ~need_w & dep_up_w) != '0);
endmodule : prs_sequencer

// ---- rtl/prs_regs.svh ----
// Constants for the power resource sequencer: config selects, defaults, timing.
// Assumes an includer that uses these as plain numbers sized at their use.
`ifndef PRS_REGS_SVH
`define PRS_REGS_SVH
// Configuration write selects
`define PRS_SEL_ON_DLY   2'h0
`define PRS_SEL_OFF_DLY  2'h1
`define PRS_SEL_DEPS     2'h2
`define PRS_SEL_MIN      2'h3
// Fixed resource positions
`define PRS_RES_BUCK     0
`define PRS_RES_CORE_LDO 1
`define PRS_RES_LN_LDO   2
`define PRS_RES_MAIN_CLK 3
// Reset values of the configuration storage
`define PRS_MIN_RESET    8'h07
`define PRS_DLY_RESET    8'h00
`define PRS_DEP_RESET    8'h00
`endif

// ---- rtl/prs_pkg.sv ----
// Types shared by the power resource sequencer modules.
// Assumes nothing of its surroundings.
package prs_pkg;
    // Phase of one resource, decoded from its state and pending flags
    typedef enum logic [1:0] {
        PRS_DISABLED,
        PRS_TURN_ON,
        PRS_ENABLED,
        PRS_TURN_OFF
    } prs_phase_t;
endpackage : prs_pkg

// ---- rtl/prs_timer_if.sv ----
// Link between the sequencer decision logic and its transition counter bank.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface prs_timer_if #(parameter int NRES = 8, parameter int DW = 8);
    logic            tick;
    logic            clr;
    logic [NRES-1:0] start_on;
    logic [NRES-1:0] start_off;
    logic [DW-1:0]   on_dly  [NRES];
    logic [DW-1:0]   off_dly [NRES];
    logic [NRES-1:0] state;
    logic [NRES-1:0] pending;
    modport ctrl (output tick, clr, start_on, start_off, on_dly, off_dly, input state, pending);
    modport bank (input tick, clr, start_on, start_off, on_dly, off_dly, output state, pending);
endinterface : prs_timer_if

// ---- rtl/prs_timer_bank.sv ----
// Per-resource transition counters with state and pending flags.
// Assumes tick is a one-cycle pulse per low-power clock period.
`timescale 1ns/1ps
module prs_timer_bank
    import prs_pkg::*;
#(
    parameter int NRES = 8,
    parameter int DW   = 8
) (
    input wire logic clk,
    input wire logic rst,
    prs_timer_if.bank  tb
);
    logic [DW-1:0]   cnt_q [NRES];
    logic [DW-1:0]   cnt_d [NRES];
    logic [NRES-1:0] st_q;
    logic [NRES-1:0] st_d;
    logic [NRES-1:0] pd_q;
    logic [NRES-1:0] pd_d;

    assign tb.state   = st_q;
    assign tb.pending = pd_q;

    // Count down on ticks only; a start is taken only by an idle counter
    always_comb begin
        for (int i = 0; i < NRES; i++) begin
            cnt_d[i] = cnt_q[i];
            st_d[i]  = st_q[i];
            pd_d[i]  = pd_q[i];
            if (tb.tick) begin
                if (cnt_q[i] != '0) begin
                    cnt_d[i] = cnt_q[i] - 1'b1; // R13 R16
                    if (cnt_q[i] == DW'(1)) begin
                        pd_d[i] = 1'b0; // R16
                        st_d[i] = ~st_q[i]; // R13
                    end
                end else if (tb.start_on[i]) begin
                    if (tb.on_dly[i] == '0) begin
                        st_d[i] = 1'b1; // R14
                    end else begin
                        cnt_d[i] = tb.on_dly[i]; // R12
                        pd_d[i]  = 1'b1;
                    end
                end else if (tb.start_off[i]) begin
                    if (tb.off_dly[i] == '0) begin
                        st_d[i] = 1'b0; // R14
                    end else begin
                        cnt_d[i] = tb.off_dly[i]; // R12
                        pd_d[i]  = 1'b1;
                    end
                end
            end
        end
    end

    // Power-down clears all, so a later power-on starts from scratch
    always_ff @(posedge clk) begin
        if (rst || tb.clr) begin
            cnt_q <= '{default: '0};
            st_q  <= '0;
            pd_q  <= '0;
        end else begin
            cnt_q <= cnt_d;
            st_q  <= st_d;
            pd_q  <= pd_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst || tb.clr);

    stable_no_tick_a: assert property (!tb.tick |=> $stable(st_q) && $stable(pd_q)) // R13
        else $error("resource state moved without a tick");
    // Per-resource checks, so that the resources given real delays are watched as well
    for (genvar g = 0; g < NRES; g++) begin : g_res
        zero_on_a: assert property (tb.tick && cnt_q[g] == '0 && tb.start_on[g] && tb.on_dly[g] == '0
            |=> st_q[g] && !pd_q[g]) // R14
            else $error("zero enable delay did not enable at once");
        count_down_a: assert property (tb.tick && cnt_q[g] > DW'(1) // R13
            |=> cnt_q[g] == $past(cnt_q[g]) - 1'b1 && pd_q[g])
            else $error("counter did not decrement");
        stable_zero_a: assert property (pd_q[g] == (cnt_q[g] != '0)) // R11
            else $error("counter nonzero outside a transition");
        turn_on_c: cover property (prs_phase_t'({st_q[g], pd_q[g]}) == PRS_TURN_ON ##1 st_q[g] && !pd_q[g]);
    end
endmodule : prs_timer_bank

// ---- verification/prs_host_model.sv ----
// Host-side model: drives the power-on, radio reset and buck mode pins and the slow oscillator clock.
// Assumes its tasks are called from one process of the bench, clocked by clk.
`timescale 1ns/1ps
module prs_host_model (
    input  wire logic clk,
    output logic      wlan_on,
    output logic      radio_on,
    output logic      radio_rst_n,
    output logic      hold_req,
    output logic      full_req,
    output logic      low_power_oscillator_clock
);
    // Every pin starts at a defined level; the reset pin is never left floating
    initial begin
        wlan_on     = 1'b0;
        radio_on    = 1'b0;
        radio_rst_n = 1'b1;
        hold_req    = 1'b0;
        full_req    = 1'b0;
        low_power_oscillator_clock         = 1'b0;
    end

    // Pins move just after an edge; three edges cover the pin flop and the output flop
    task automatic set_pins(input logic w, input logic r, input logic n, input logic h, input logic f);
        @(posedge clk);
        #1;
        wlan_on     = w;
        radio_on    = r;
        radio_rst_n = n;
        hold_req    = h;
        full_req    = f;
        repeat (3) @(posedge clk);
        #1;
    endtask : set_pins

    // One slow period; the clock stays low between calls so no stray tick is seen
    task automatic lpo_tick();
        @(posedge clk);
        #1;
        low_power_oscillator_clock = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        low_power_oscillator_clock = 1'b0;
        repeat (4) @(posedge clk);
        #1;
    endtask : lpo_tick
endmodule : prs_host_model

// ---- verification/tb_top.sv ----
// Self-checking bench for the power resource sequencer.
// Assumes the host model owns the pins and ticks; the bench owns requests and configuration.
`timescale 1ns/1ps
`include "prs_regs.svh"
module tb_top;
    logic       CLOCK;
    logic       RST;
    logic       wlan_on, radio_on, radio_rst_n, hold_req, full_req, low_power_oscillator_clock;
    logic       BUCK_PWM_INTERNAL_REQ;
    logic [3:0] CORE_CLOCK_REQ;
    logic [7:0] TIMER_REQ;
    logic       CFG_WE;
    logic [1:0] CFG_SEL;
    logic [2:0] CFG_IDX;
    logic [7:0] CFG_DATA;
    logic       REG_ENABLE, BUCK_ENABLE, BUCK_PWM_MODE, CORE_LINEAR_ENABLE, LOW_NOISE_ENABLE;
    logic       WLAN_SECTION_RESET, RADIO_CORE_RESET, MAIN_CLOCK_ENABLE, DOZE_STATE;
    logic       IO_OUTPUT_ENABLE_N, IO_INPUT_ENABLE;
    logic [7:0] RESOURCE_STATE_FLAG, RESOURCE_PENDING_FLAG;
    int         fails;
    int         check_count;

    prs_host_model prs_host_model_i (.clk(CLOCK), .wlan_on(wlan_on), .radio_on(radio_on),
        .radio_rst_n(radio_rst_n), .hold_req(hold_req), .full_req(full_req), .low_power_oscillator_clock(low_power_oscillator_clock));

    prs_sequencer prs_sequencer_i (.CLOCK(CLOCK), .RST(RST), .WLAN_POWER_ON_INPUT(wlan_on),
        .RADIO_POWER_ON_INPUT(radio_on), .RADIO_CORE_RESET_N(radio_rst_n), .SWITCHER_HOLD_REQUEST(hold_req),
        .BUCK_FULL_POWER_REQUEST(full_req), .BUCK_PWM_INTERNAL_REQ(BUCK_PWM_INTERNAL_REQ),
        .LPO_CLOCK_IN(low_power_oscillator_clock), .CORE_CLOCK_REQ(CORE_CLOCK_REQ), .TIMER_REQ(TIMER_REQ), .CFG_WE(CFG_WE),
        .CFG_SEL(CFG_SEL), .CFG_IDX(CFG_IDX), .CFG_DATA(CFG_DATA), .REG_ENABLE(REG_ENABLE),
        .BUCK_ENABLE(BUCK_ENABLE), .BUCK_PWM_MODE(BUCK_PWM_MODE), .CORE_LINEAR_ENABLE(CORE_LINEAR_ENABLE),
        .LOW_NOISE_ENABLE(LOW_NOISE_ENABLE), .WLAN_SECTION_RESET(WLAN_SECTION_RESET),
        .RADIO_CORE_RESET(RADIO_CORE_RESET), .MAIN_CLOCK_ENABLE(MAIN_CLOCK_ENABLE), .DOZE_STATE(DOZE_STATE),
        .IO_OUTPUT_ENABLE_N(IO_OUTPUT_ENABLE_N), .IO_INPUT_ENABLE(IO_INPUT_ENABLE),
        .RESOURCE_STATE_FLAG(RESOURCE_STATE_FLAG), .RESOURCE_PENDING_FLAG(RESOURCE_PENDING_FLAG));

    // 40 MHz clock
    always #12.5 CLOCK = ~CLOCK;

    // Compare seen against expected; four-state equality so unknowns never match
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count = check_count + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One-cycle configuration write strobe, launched just after an edge
    task automatic cfg_write(input logic [1:0] sel, input logic [2:0] idx, input logic [7:0] data);
        @(posedge CLOCK);
        #1;
        CFG_WE   = 1'b1;
        CFG_SEL  = sel;
        CFG_IDX  = idx;
        CFG_DATA = data;
        @(posedge CLOCK);
        #1;
        CFG_WE = 1'b0;
    endtask : cfg_write

    task automatic results();
        if (fails == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results

    // Watchdog: the sequence needs well under a thousand cycles
    initial begin
        #(25 * 4000);
        fails = fails + 1;
        results();
    end

    // Main sequence
    initial begin
        CLOCK = 1'b0;
        RST = 1'b1;
        fails = 0;
        check_count = 0;
        BUCK_PWM_INTERNAL_REQ = 1'b0;
        CORE_CLOCK_REQ = 4'h0;
        TIMER_REQ = 8'h00;
        CFG_WE = 1'b0;
        CFG_SEL = 2'h0;
        CFG_IDX = 3'h0;
        CFG_DATA = 8'h00;
        repeat (2) @(posedge CLOCK);
        #1;
        RST = 1'b0;
        check({REG_ENABLE, BUCK_ENABLE, WLAN_SECTION_RESET, RADIO_CORE_RESET, IO_OUTPUT_ENABLE_N,
               IO_INPUT_ENABLE, MAIN_CLOCK_ENABLE, CORE_LINEAR_ENABLE}, 8'h38);
        check(RESOURCE_STATE_FLAG, 8'h00);
        // Every power-on combination: regulators, WLAN reset and pad state
        for (int i = 0; i < 4; i++) begin
            prs_host_model_i.set_pins(i[1], i[0], 1'b1, 1'b0, 1'b0);
            check({4'h0, REG_ENABLE, WLAN_SECTION_RESET, IO_OUTPUT_ENABLE_N, IO_INPUT_ENABLE},
                  {4'h0, i[1] | i[0], ~i[1], ~(i[1] | i[0]), i[1] | i[0]});
        end
        // Radio reset touches only the radio core
        prs_host_model_i.set_pins(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        check({5'h0, RADIO_CORE_RESET, WLAN_SECTION_RESET, REG_ENABLE}, 8'h05);
        prs_host_model_i.set_pins(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
        check({5'h0, RADIO_CORE_RESET, WLAN_SECTION_RESET, REG_ENABLE}, 8'h01);
        // Minimum mask brings up the regulators; main clock stays off, so doze
        prs_host_model_i.lpo_tick();
        check(RESOURCE_STATE_FLAG, 8'h07);
        check({3'h0, BUCK_ENABLE, CORE_LINEAR_ENABLE, LOW_NOISE_ENABLE, MAIN_CLOCK_ENABLE, DOZE_STATE},
              8'h1d);
        CORE_CLOCK_REQ = 4'h1;
        prs_host_model_i.lpo_tick();
        check(RESOURCE_STATE_FLAG, 8'h0f);
        check({6'h0, MAIN_CLOCK_ENABLE, DOZE_STATE}, 8'h02);
        CORE_CLOCK_REQ = 4'h0;
        prs_host_model_i.lpo_tick();
        check(RESOURCE_STATE_FLAG, 8'h07);
        // Linear regulators follow the resource needs
        cfg_write(`PRS_SEL_MIN, 3'h0, 8'h01);
        prs_host_model_i.lpo_tick();
        check({5'h0, BUCK_ENABLE, CORE_LINEAR_ENABLE, LOW_NOISE_ENABLE}, 8'h04);
        cfg_write(`PRS_SEL_MIN, 3'h0, 8'h07);
        prs_host_model_i.lpo_tick();
        check({5'h0, BUCK_ENABLE, CORE_LINEAR_ENABLE, LOW_NOISE_ENABLE}, 8'h07);
        // Enable delay of 3: pending on the first tick, enabled three ticks later
        cfg_write(`PRS_SEL_ON_DLY, 3'h4, 8'h03);
        TIMER_REQ = 8'h10;
        prs_host_model_i.lpo_tick();
        check({6'h0, RESOURCE_STATE_FLAG[4], RESOURCE_PENDING_FLAG[4]}, 8'h01);
        repeat (2) prs_host_model_i.lpo_tick();
        check({6'h0, RESOURCE_STATE_FLAG[4], RESOURCE_PENDING_FLAG[4]}, 8'h01);
        prs_host_model_i.lpo_tick();
        check({6'h0, RESOURCE_STATE_FLAG[4], RESOURCE_PENDING_FLAG[4]}, 8'h02);
        TIMER_REQ = 8'h00;
        prs_host_model_i.lpo_tick();
        check({6'h0, RESOURCE_STATE_FLAG[4], RESOURCE_PENDING_FLAG[4]}, 8'h00);
        // Resource 5 depends on 4: up one tick after it, down one tick before it
        cfg_write(`PRS_SEL_ON_DLY, 3'h4, 8'h00);
        cfg_write(`PRS_SEL_DEPS, 3'h5, 8'h10);
        TIMER_REQ = 8'h20;
        prs_host_model_i.lpo_tick();
        check({6'h0, RESOURCE_STATE_FLAG[5:4]}, 8'h01);
        prs_host_model_i.lpo_tick();
        check({6'h0, RESOURCE_STATE_FLAG[5:4]}, 8'h03);
        TIMER_REQ = 8'h00;
        prs_host_model_i.lpo_tick();
        check({6'h0, RESOURCE_STATE_FLAG[5:4]}, 8'h01);
        prs_host_model_i.lpo_tick();
        check({6'h0, RESOURCE_STATE_FLAG[5:4]}, 8'h00);
        // Switcher hold and the buck mode contention
        prs_host_model_i.set_pins(1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
        check({5'h0, REG_ENABLE, BUCK_ENABLE, BUCK_PWM_MODE}, 8'h02);
        prs_host_model_i.set_pins(1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
        check({7'h0, BUCK_PWM_MODE}, 8'h00);
        prs_host_model_i.set_pins(1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
        check({7'h0, BUCK_PWM_MODE}, 8'h01);
        prs_host_model_i.set_pins(1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
        check({7'h0, BUCK_PWM_MODE}, 8'h00);
        BUCK_PWM_INTERNAL_REQ = 1'b1;
        repeat (3) @(posedge CLOCK);
        #1;
        check({7'h0, BUCK_PWM_MODE}, 8'h01);
        BUCK_PWM_INTERNAL_REQ = 1'b0;
        // Full power-down, a refused write, then a fresh power-up
        prs_host_model_i.set_pins(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
        check({1'b0, REG_ENABLE, BUCK_ENABLE, CORE_LINEAR_ENABLE, LOW_NOISE_ENABLE, MAIN_CLOCK_ENABLE,
               IO_OUTPUT_ENABLE_N, IO_INPUT_ENABLE}, 8'h02);
        check(RESOURCE_STATE_FLAG, 8'h00);
        cfg_write(`PRS_SEL_ON_DLY, 3'h4, 8'h02);
        TIMER_REQ = 8'h10;
        prs_host_model_i.set_pins(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
        check(RESOURCE_STATE_FLAG, 8'h00);
        prs_host_model_i.lpo_tick();
        check(RESOURCE_STATE_FLAG, 8'h17);
        // Disable delay of 2: turning off on the first tick, disabled two ticks later
        cfg_write(`PRS_SEL_OFF_DLY, 3'h4, 8'h02);
        TIMER_REQ = 8'h00;
        prs_host_model_i.lpo_tick();
        check({6'h0, RESOURCE_STATE_FLAG[4], RESOURCE_PENDING_FLAG[4]}, 8'h03);
        prs_host_model_i.lpo_tick();
        check({6'h0, RESOURCE_STATE_FLAG[4], RESOURCE_PENDING_FLAG[4]}, 8'h03);
        prs_host_model_i.lpo_tick();
        check({6'h0, RESOURCE_STATE_FLAG[4], RESOURCE_PENDING_FLAG[4]}, 8'h00);
        results();
    end
endmodule : tb_top
